// ==== design/hsp_sequencer.sv ====
// hot-swap card power mode sequencer with apb register slave
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps

module hsp_sequencer #(
    parameter int SCAN_SLOT_CYCLES = hsp_pkg::SLOT_CYCLES
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  SYS_RST,
    input  wire hsp_pkg::apb_req_t     APB_REQ,
    output hsp_pkg::apb_rsp_t          APB_RSP,
    input  wire logic                  HOST_POWER_REQUEST,
    input  wire logic                  FORCED_SHUTDOWN_IN,
    input  wire logic                  CARD_3V3_MONITOR,
    input  wire logic                  MONITOR_A,
    input  wire logic                  ADC_DONE,
    input  wire logic [9:0]            ADC_DATA,
    output logic                       ADC_START,
    output logic [2:0]                 ADC_CHANNEL,
    output logic [2:0]                 CONVERTER_ENABLE,
    output logic [1:0]                 FET_GATE_DRIVE,
    output logic                       HIGH_SIDE_12V_ENABLE,
    output logic [2:0]                 TRIM_ACTIVE,
    output logic [5:0]                 TRIM_SELECT,
    output logic                       CARD_RESET,
    output logic                       POWER_GOOD,
    output logic                       FAULT
);

    // ========================================
    // helpers

    // channel held in slot idx of the order word
    function automatic logic [2:0] slot_of(
        input logic [17:0] order,
        input logic [2:0]  idx
    );
        logic [2:0] ch;
        ch = order[idx * 3 +: 3];
        return ch;
    endfunction

    // ========================================
    // registers and state

    hsp_pkg::ctrl_t  ctrl;
    logic [17:0]     order;
    logic [15:0]     timeout;
    logic [5:0]      margin;
    hsp_pkg::limit_t limit [hsp_pkg::ADC_CHANNELS];

    hsp_pkg::mode_t  mode;
    logic [2:0]      step;
    logic [5:0]      chan_en;
    logic [15:0]     seq_timer;
    logic            by_host;
    logic            fault;
    logic [7:0]      under;
    logic [7:0]      over;

    logic [3:0]      sync_a;
    logic [3:0]      sync_b;
    logic            host_prev;

    logic [hsp_pkg::SLOT_W-1:0] slot_cnt;
    logic            slot_tick;

    logic [31:0]     rdata;
    logic            rerr;
    logic [31:0]     rd_word;
    logic            rd_err;

    // ========================================
    // pin synchronisers

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {MONITOR_A, CARD_3V3_MONITOR,
                       FORCED_SHUTDOWN_IN, HOST_POWER_REQUEST};
            sync_b <= sync_a;
        end
    end

    logic host_on;
    logic fs_on;
    logic host_rise;

    assign host_on   = sync_b[0] ^ ctrl.host_pol;
    assign fs_on     = sync_b[1] ^ ctrl.fs_pol;
    assign host_rise = host_on & ~host_prev;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            host_prev <= 1'b0;
        end else begin
            host_prev <= host_on;
        end
    end

    // ========================================
    // apb access

    logic       acc;
    logic       wr;
    logic [7:0] addr;
    logic       lim_hit;
    logic [2:0] lim_idx;

    assign acc     = APB_REQ.psel & APB_REQ.penable;
    assign wr      = acc & APB_REQ.pwrite;
    assign addr    = APB_REQ.paddr;
    assign lim_hit = (addr[7:5] == hsp_pkg::ADDR_LIMIT[7:5]) & (addr[1:0] == 2'h0);
    assign lim_idx = addr[hsp_pkg::LIMIT_IDX_MSB:2];

    logic [3:0] cmd;

    // commands are one-cycle pulses, never stored
    assign cmd = (wr & (addr == hsp_pkg::ADDR_CMD)) ? APB_REQ.pwdata[3:0] : 4'h0;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ctrl    <= '0;
            order   <= hsp_pkg::ORDER_RESET;
            timeout <= hsp_pkg::TIMEOUT_RESET;
            margin  <= 6'h00;
            for (int i = 0; i < hsp_pkg::ADC_CHANNELS; i++) begin
                limit[i] <= '{ov: hsp_pkg::OV_RESET, uv: hsp_pkg::UV_RESET};
            end
        end else if (wr) begin
            if (addr == hsp_pkg::ADDR_CTRL) begin
                ctrl <= hsp_pkg::ctrl_t'(APB_REQ.pwdata[hsp_pkg::CTRL_W-1:0]);
            end
            if (addr == hsp_pkg::ADDR_ORDER) begin
                order <= APB_REQ.pwdata[17:0];
            end
            if (addr == hsp_pkg::ADDR_TIMEOUT) begin
                timeout <= APB_REQ.pwdata[15:0];
            end
            if (addr == hsp_pkg::ADDR_MARGIN) begin
                margin <= APB_REQ.pwdata[5:0];
            end
            if (lim_hit) begin
                limit[lim_idx] <= '{
                    ov: APB_REQ.pwdata[hsp_pkg::OV_LSB +: hsp_pkg::ADC_W],
                    uv: APB_REQ.pwdata[hsp_pkg::ADC_W-1:0]};
            end
        end
    end

    always_comb begin
        rd_word = 32'h0;
        rd_err  = 1'b0;
        if (lim_hit) begin
            rd_word = {6'h00, limit[lim_idx].ov, 6'h00, limit[lim_idx].uv};
        end else begin
            unique case (addr)
                hsp_pkg::ADDR_CTRL:    rd_word = {19'h0, ctrl};
                hsp_pkg::ADDR_ORDER:   rd_word = {14'h0, order};
                hsp_pkg::ADDR_TIMEOUT: rd_word = {16'h0, timeout};
                hsp_pkg::ADDR_MARGIN:  rd_word = {26'h0, margin};
                hsp_pkg::ADDR_CMD:     rd_word = 32'h0;
                hsp_pkg::ADDR_STATUS:
                    rd_word = {4'h0, over, under, fault, chan_en, mode};
                default:               rd_err  = 1'b1;
            endcase
        end
    end

    // read data captured in the setup cycle, so access needs no wait
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rdata <= 32'h0;
            rerr  <= 1'b0;
        end else if (APB_REQ.psel & ~APB_REQ.penable) begin
            rdata <= APB_REQ.pwrite ? 32'h0 : rd_word;
            rerr  <= rd_err;
        end
    end

    assign APB_RSP = '{prdata: rdata, pready: 1'b1, pslverr: rerr};

    // ========================================
    // channel scan

    // one slot per channel, full pass in 2 ms
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            slot_cnt  <= '0;
            slot_tick <= 1'b0;
        end else if (slot_cnt == hsp_pkg::SLOT_W'(SCAN_SLOT_CYCLES - 1)) begin
            slot_cnt  <= '0;
            slot_tick <= 1'b1;
        end else begin
            slot_cnt  <= slot_cnt + 1'b1;
            slot_tick <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ADC_START   <= 1'b0;
            ADC_CHANNEL <= 3'h0;
        end else begin
            ADC_START <= slot_tick;
            // channel moves with the start pulse, so done belongs to it
            if (slot_tick) begin
                ADC_CHANNEL <= ADC_CHANNEL + 1'b1;
            end
        end
    end

    // compare every result against its limits
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            under <= 8'hff;
            over  <= 8'h00;
        end else if (ADC_DONE) begin
            under[ADC_CHANNEL]  <= ADC_DATA < limit[ADC_CHANNEL].uv;
            over[ADC_CHANNEL]   <= ADC_DATA > limit[ADC_CHANNEL].ov;
        end
    end

    // ========================================
    // trip decode

    logic [5:0] out_rng;
    logic       trip;
    logic       hard_trip;
    logic       all_up;

    assign out_rng = under[5:0] | over[5:0];
    assign trip    = |out_rng;
    assign all_up  = ~|under[5:0];

    // 12v, 5v, 3v3 limits force immediate shutdown in monitor only
    assign hard_trip = ctrl.uvov_kill & (out_rng[hsp_pkg::CH_3V3]
                     | out_rng[hsp_pkg::CH_5V] | out_rng[hsp_pkg::CH_12V]);

    // ========================================
    // sequencing

    logic [2:0] cur_ch;
    logic       cur_ok;
    logic       reached;
    logic       timed_out;
    logic       start;

    // power-off walks order forward or reversed
    assign cur_ch = (mode == hsp_pkg::ST_PWR_OFF && ctrl.reverse_off)
                  ? slot_of(order, hsp_pkg::LAST_STEP - step)
                  : slot_of(order, step);
    assign cur_ok = cur_ch <= hsp_pkg::LAST_STEP;

    assign reached = ~cur_ok
                   | ((mode == hsp_pkg::ST_PWR_ON) ? ~under[cur_ch] : under[cur_ch]);

    assign timed_out = (timeout != 16'h0) & (seq_timer >= timeout);

    assign start = host_on & (host_rise | cmd[hsp_pkg::CMD_ON]) & ~fs_on;

    always_ff @(posedge CORE_CLK) begin
        // timer only runs while a sequence waits on a rail
        if (SYS_RST | reached | ((mode != hsp_pkg::ST_PWR_ON)
                                 & (mode != hsp_pkg::ST_PWR_OFF))) begin
            seq_timer <= 16'h0;
        end else if (slot_tick) begin
            seq_timer <= seq_timer + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mode    <= hsp_pkg::ST_IDLE;
            step    <= 3'h0;
            chan_en <= 6'h00;
            by_host <= 1'b0;
        end else begin
            unique case (mode)
                hsp_pkg::ST_IDLE: begin
                    step <= 3'h0;
                    if (start) begin
                        mode    <= hsp_pkg::ST_PWR_ON;
                        by_host <= host_rise;
                    end
                end
                hsp_pkg::ST_PWR_ON: begin
                    // forced shutdown; no power without request
                    if (fs_on | ~host_on) begin
                        chan_en <= 6'h00;
                        mode    <= hsp_pkg::ST_IDLE;
                    end else if (timed_out) begin
                        chan_en <= 6'h00;
                        mode    <= hsp_pkg::ST_IDLE;
                    end else begin
                        if (cur_ok) begin
                            chan_en[cur_ch] <= 1'b1;
                        end
                        if (reached) begin
                            step <= step + 1'b1;
                            if (step == hsp_pkg::LAST_STEP) begin
                                mode <= hsp_pkg::ST_MONITOR;
                            end
                        end
                    end
                end
                hsp_pkg::ST_MONITOR: begin
                    step <= 3'h0;
                    if (fs_on | hard_trip) begin
                        chan_en <= 6'h00;
                        mode    <= hsp_pkg::ST_IDLE;
                    // host drop, command or trip; only from here
                    end else if (~host_on | cmd[hsp_pkg::CMD_OFF]
                                 | (ctrl.trip_off & trip)) begin
                        mode <= hsp_pkg::ST_PWR_OFF;
                    // margin only on command from monitor
                    end else if (cmd[hsp_pkg::CMD_MARGIN]) begin
                        mode <= hsp_pkg::ST_MARGIN;
                    end
                end
                hsp_pkg::ST_MARGIN: begin
                    // no trip or shutdown acted on here
                    if (cmd[hsp_pkg::CMD_MARGIN_EXIT] | ~host_on) begin
                        mode <= hsp_pkg::ST_MONITOR;
                    end
                end
                hsp_pkg::ST_PWR_OFF: begin
                    if (fs_on | (ctrl.off_timeout_en & timed_out)) begin
                        chan_en <= 6'h00;
                        mode    <= hsp_pkg::ST_IDLE;
                    end else begin
                        if (cur_ok) begin
                            chan_en[cur_ch] <= 1'b0;
                        end
                        if (reached) begin
                            step <= step + 1'b1;
                            if (step == hsp_pkg::LAST_STEP) begin
                                mode <= hsp_pkg::ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ========================================
    // fault latch

    logic fault_src;
    logic gate_again;

    assign fault_src = (ctrl.temp_fault & (over[hsp_pkg::CH_TINT] | over[hsp_pkg::CH_TEXT]))
                     | (ctrl.ovc_fault & (sync_b[2] | sync_b[3]));

    // gate first re-enabled after a host cycle
    assign gate_again = (mode == hsp_pkg::ST_PWR_ON) & by_host & ~fs_on & host_on
                      & ~timed_out & ((cur_ch == hsp_pkg::CH_3V3) | (cur_ch == hsp_pkg::CH_5V))
                      & ~chan_en[cur_ch];

    // set beats release in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fault <= 1'b0;
        end else begin
            fault <= fault_src | (fault & ~gate_again);
        end
    end

    // ========================================
    // card outputs

    logic good;

    // only monitor and margin report good
    // trips gate good in monitor, never in margin
    assign good = (mode == hsp_pkg::ST_MARGIN)
                | ((mode == hsp_pkg::ST_MONITOR) & ~(ctrl.trip_reset & trip) & ~hard_trip);

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CARD_RESET <= 1'b1;
            POWER_GOOD <= 1'b0;
            FAULT      <= 1'b0;
        end else begin
            CARD_RESET <= ~good ^ ctrl.reset_pol;
            POWER_GOOD <= good ^ ctrl.pgood_pol;
            FAULT      <= fault ^ ctrl.fault_pol;
        end
    end

    always_comb begin
        CONVERTER_ENABLE     = chan_en[2:0];
        FET_GATE_DRIVE       = chan_en[4:3];
        HIGH_SIDE_12V_ENABLE = chan_en[5];
    end

    // ========================================
    // trim control

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            TRIM_ACTIVE <= 3'h0;
            TRIM_SELECT <= 6'h00;
        end else if (mode == hsp_pkg::ST_MARGIN) begin
            TRIM_ACTIVE <= {3{ctrl.trim_en}};
            TRIM_SELECT <= margin;
        end else begin
            // trim to nominal in monitor once all supplies up; off otherwise
            TRIM_ACTIVE <= {3{ctrl.trim_en & all_up & (mode == hsp_pkg::ST_MONITOR)}};
            TRIM_SELECT <= {3{hsp_pkg::TRIM_NOMINAL}};
        end
    end

endmodule

// ==== design/hsp_pkg.sv ====
// constants, encodings and carriers for the hot-swap power mode sequencer
package hsp_pkg;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int SCAN_PASS_NS    = 2000000;
    localparam int ADC_CHANNELS    = 8;
    localparam int SLOT_CYCLES     = SCAN_PASS_NS / (CLK_PERIOD_NS * ADC_CHANNELS);
    localparam int SLOT_W          = 17;

    // ========================================
    // channels
    localparam int SUPPLIES        = 6;
    localparam int ADC_W           = 10;
    localparam logic [2:0] CH_3V3  = 3'h3;
    localparam logic [2:0] CH_5V   = 3'h4;
    localparam logic [2:0] CH_12V  = 3'h5;
    localparam logic [2:0] CH_TINT = 3'h6;
    localparam logic [2:0] CH_TEXT = 3'h7;
    localparam logic [2:0] LAST_STEP = 3'h5;

    // ========================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_ORDER   = 8'h04;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
    localparam logic [7:0] ADDR_MARGIN  = 8'h0c;
    localparam logic [7:0] ADDR_CMD     = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_LIMIT   = 8'h20;
    localparam logic [2:0] LIMIT_IDX_MSB = 3'h4;
    localparam int OV_LSB              = 16;

    // command bits in the CMD register
    localparam int CMD_ON          = 0;
    localparam int CMD_OFF         = 1;
    localparam int CMD_MARGIN      = 2;
    localparam int CMD_MARGIN_EXIT = 3;

    // reset values
    localparam logic [17:0] ORDER_RESET   = 18'h2c688;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0010;
    localparam logic [ADC_W-1:0] UV_RESET = 10'h000;
    localparam logic [ADC_W-1:0] OV_RESET = 10'h3ff;

    // converter trim targets
    localparam logic [1:0] TRIM_NOMINAL = 2'h0;

    // ========================================
    // types
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_PWR_ON  = 5'b00010,
        ST_MONITOR = 5'b00100,
        ST_MARGIN  = 5'b01000,
        ST_PWR_OFF = 5'b10000
    } mode_t;

    typedef struct packed {
        logic fault_pol;
        logic pgood_pol;
        logic reset_pol;
        logic fs_pol;
        logic host_pol;
        logic ovc_fault;
        logic temp_fault;
        logic off_timeout_en;
        logic trip_reset;
        logic trip_off;
        logic uvov_kill;
        logic reverse_off;
        logic trim_en;
    } ctrl_t;

    localparam int CTRL_W = 13;

    typedef struct packed {
        logic [ADC_W-1:0] ov;
        logic [ADC_W-1:0] uv;
    } limit_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

// ==== verification/hsp_sequencer_properties.sv ====
// concurrent checks on the mode sequencer ports
`timescale 1ns/1ps
module hsp_sequencer_checker #(
    parameter int SCAN_SLOT_CYCLES = hsp_pkg::SLOT_CYCLES
) (
    input wire logic       CORE_CLK,
    input wire logic       SYS_RST,
    input wire logic       HOST_POWER_REQUEST,
    input wire logic       ADC_START,
    input wire logic [2:0] ADC_CHANNEL,
    input wire logic [2:0] CONVERTER_ENABLE,
    input wire logic [1:0] FET_GATE_DRIVE,
    input wire logic       HIGH_SIDE_12V_ENABLE,
    input wire logic       CARD_RESET,
    input wire logic       POWER_GOOD,
    input wire logic       FAULT
);
    wire logic [5:0] en = {HIGH_SIDE_12V_ENABLE, FET_GATE_DRIVE, CONVERTER_ENABLE};
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // slot length counted, too long for a plain delay
    int   gap;
    logic seen;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            gap  <= 0;
            seen <= 1'b0;
        end else begin
            gap  <= ADC_START ? 0 : gap + 1;
            seen <= seen | ADC_START;
        end
    end
    // ==========
    // sequencing
    chk_reset_off: assert property (
        $fell(SYS_RST) |-> en == 6'h00 && CARD_RESET && !POWER_GOOD && !FAULT)
        else $error("outputs not off after reset");
    chk_one_step: assert property (
        $countones(en) <= $countones($past(en)) + 1) else $error("two rails at once");
    chk_good_all_on: assert property (
        $rose(POWER_GOOD) |-> en == 6'h3f && $fell(CARD_RESET))
        else $error("good without all rails");
    chk_good_reset_excl: assert property (
        !(POWER_GOOD && CARD_RESET)) else $error("good and reset both active");
    chk_host_low_reset: assert property (
        !HOST_POWER_REQUEST [*8] |-> CARD_RESET) else $error("reset free without host");
    chk_fault_release: assert property (
        $fell(FAULT) |-> $past(|FET_GATE_DRIVE) && !$past(|FET_GATE_DRIVE, 2))
        else $error("fault freed off gate edge");
    // ==========
    // scan
    chk_scan_pulse: assert property (
        ADC_START |=> !ADC_START [*8]) else $error("start pulse too long");
    chk_scan_slot: assert property (
        seen |-> ADC_START == (gap == SCAN_SLOT_CYCLES - 1)) else $error("slot length wrong");
    chk_chan_step: assert property (
        ADC_START |-> ADC_CHANNEL == $past(ADC_CHANNEL) + 3'h1) else $error("channel skip");
    cov_good: cover property ($rose(POWER_GOOD));
    cov_fault_free: cover property ($fell(FAULT));
    cov_kill: cover property ($fell(|en) && !POWER_GOOD);
endmodule

bind hsp_sequencer hsp_sequencer_checker #(.SCAN_SLOT_CYCLES(SCAN_SLOT_CYCLES))
    hsp_sequencer_checker_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .HOST_POWER_REQUEST(HOST_POWER_REQUEST), .ADC_START(ADC_START),
    .ADC_CHANNEL(ADC_CHANNEL), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .FET_GATE_DRIVE(FET_GATE_DRIVE), .HIGH_SIDE_12V_ENABLE(HIGH_SIDE_12V_ENABLE),
    .CARD_RESET(CARD_RESET), .POWER_GOOD(POWER_GOOD), .FAULT(FAULT));

// ==== verification/card_rail_model.sv ====
// supply rails and scan converter seen from the sequencer
`timescale 1ns/1ps
module card_rail_model (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [2:0] chan,
    input  wire logic [5:0] en,
    input  wire logic [5:0] drop,
    output logic            done,
    output logic [9:0]      data
);
    logic [2:0] cap = 3'h0;
    logic [1:0] dly = 2'h0;
    initial done = 1'b0;
    initial data = 10'h000;
    // ==========
    // enabled rail sits above threshold
    always @(posedge clk) begin
        dly  <= {dly[0], start};
        done <= dly[1];
        cap  <= start ? chan : cap;
        // idle bus toggles so no stale result looks valid
        data <= (dly[1] && cap < 3'h6 && en[cap] && !drop[cap]) ? 10'h200
              : dly[1] ? 10'h000 : ~data;
    end
endmodule

// ==== verification/tb_hsp_sequencer.sv ====
// self-checking bench for the hot-swap mode sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_hsp_sequencer;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        r;
    } row_t;
    logic              clk = 1'b0, rst = 1'b1, host = 1'b0, fs = 1'b0, oca = 1'b0, oc3 = 1'b0;
    logic              done, start, hs, crst, pgood, fault, e;
    logic [9:0]        data;
    logic [2:0]        ch, conv, trm;
    logic [1:0]        fet;
    logic [5:0]        tsel, drop = 6'h00, en_q = 6'h00;
    logic [31:0]       q;
    hsp_pkg::apb_req_t req = '0;
    hsp_pkg::apb_rsp_t rsp;
    int                n_mismatch = 0, checks_done = 0;
    int                ord[$];
    wire logic [5:0]   en = {hs, fet, conv};
    row_t              rows[13] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0002c688, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h10, 1'b0}, '{1'b0, 8'h3c, 32'h0, 32'h03ff0000, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h1c, 32'h5, 32'h0, 1'b1}, '{1'b1, 8'h04, 32'h14e5, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h14e5, 1'b0}, '{1'b1, 8'h08, 32'h14, 32'h0, 1'b0},
        '{1'b1, 8'h0c, 32'h24, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'h85, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h0, 32'h85, 1'b0}};

    hsp_sequencer #(.SCAN_SLOT_CYCLES(16)) hsp_sequencer_inst (
        .CORE_CLK(clk), .SYS_RST(rst), .APB_REQ(req), .APB_RSP(rsp),
        .HOST_POWER_REQUEST(host), .FORCED_SHUTDOWN_IN(fs), .CARD_3V3_MONITOR(oc3),
        .MONITOR_A(oca), .ADC_DONE(done), .ADC_DATA(data), .ADC_START(start),
        .ADC_CHANNEL(ch), .CONVERTER_ENABLE(conv), .FET_GATE_DRIVE(fet),
        .HIGH_SIDE_12V_ENABLE(hs), .TRIM_ACTIVE(trm), .TRIM_SELECT(tsel),
        .CARD_RESET(crst), .POWER_GOOD(pgood), .FAULT(fault));
    card_rail_model card_rail_model_inst (.clk(clk), .start(start), .chan(ch), .en(en),
        .drop(drop), .done(done), .data(data));

    initial begin
        forever #2.5 clk = ~clk;
    end
    // rail switch history: index on, index+8 off
    always @(posedge clk) begin
        for (int i = 0; i < 6; i++) if (en[i] !== en_q[i]) ord.push_back(en[i] ? i : i + 8);
        en_q <= en;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        i = 0;
        do begin @(posedge clk); i++; end while (rsp.pready !== 1'b1 && i < 20);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clk);
        if (i >= 20) begin n_mismatch++; final_report(); end
    endtask
    task automatic wait_mode(input logic [4:0] m);
        int i;
        // stale status never counts as reached
        q = 32'h0;
        for (i = 0; i < 3000 && q[4:0] !== m; i++) apb(1'b0, hsp_pkg::ADDR_STATUS, '0);
        `CHK(q[4:0], m)
        if (i == 3000) final_report();
    endtask
    task automatic chk_ord(input int s0, input int st);
        `CHK(ord.size(), 6)
        for (int i = 0; i < 6 && i < ord.size(); i++) `CHK(ord[i], s0 + st * i)
        ord.delete();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) `CHK(q, rows[i].x)
            `CHK(e, rows[i].r)
        end
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h4);
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h2);
        wait_mode(5'h01);
        for (int i = 0; i < 6; i++) apb(1'b1, 8'h20 + 8'(4 * i), 32'h03ff0100);
        // rescan so every rail reads under against the new floors
        repeat (8 * 16 + 16) @(posedge clk);
        ord.delete();
        host <= 1'b1;
        wait_mode(5'h04);
        chk_ord(5, -1);
        // one scan pass plus a slot so trim sees every rail above its floor
        repeat (8 * 16 + 16) @(posedge clk);
        `CHK({pgood, crst, trm}, 5'h17)
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h4);
        wait_mode(5'h08);
        `CHK(tsel, 6'h24)
        fs <= 1'b1;
        drop <= 6'h10;
        repeat (200) @(posedge clk);
        `CHK({en, pgood, crst}, 8'hfe)
        fs <= 1'b0;
        drop <= 6'h00;
        repeat (200) @(posedge clk);
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h8);
        wait_mode(5'h04);
        `CHK(tsel, 6'h00)
        ord.delete();
        host <= 1'b0;
        wait_mode(5'h01);
        chk_ord(13, -1);
        `CHK({trm, crst, pgood}, 5'h02)
        oca <= 1'b1;
        repeat (10) @(posedge clk);
        oca <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(fault, 1'b1)
        host <= 1'b1;
        wait_mode(5'h04);
        `CHK(fault, 1'b0)
        drop <= 6'h08;
        wait_mode(5'h01);
        `CHK({en, crst}, 7'h01)
        host <= 1'b0;
        repeat (10) @(posedge clk);
        drop <= 6'h20;
        host <= 1'b1;
        wait_mode(5'h02);
        wait_mode(5'h01);
        `CHK(en, 6'h00)
        oc3 <= 1'b1;
        repeat (10) @(posedge clk);
        oc3 <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(fault, 1'b1)
        drop <= 6'h00;
        host <= 1'b0;
        repeat (10) @(posedge clk);
        host <= 1'b1;
        wait_mode(5'h04);
        `CHK(fault, 1'b0)
        fs <= 1'b1;
        wait_mode(5'h01);
        `CHK(en, 6'h00)
        fs <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h1);
        wait_mode(5'h04);
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h2);
        wait_mode(5'h01);
        apb(1'b1, hsp_pkg::ADDR_CMD, 32'h1);
        wait_mode(5'h04);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({en, crst, pgood, fault}, 9'h004)
        final_report();
    end
endmodule
